/* design/sbt_pkg.sv */
package sbt_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL_A   = 8'h00;
	localparam logic [7:0] OFF_CTRL_B   = 8'h04;
	localparam logic [7:0] OFF_CTRL_C   = 8'h08;
	localparam logic [7:0] OFF_FLAGS    = 8'h0c;
	localparam logic [7:0] OFF_MASK     = 8'h10;
	localparam logic [7:0] OFF_POWER    = 8'h14;
	localparam logic [7:0] OFF_COUNT_LO = 8'h18;
	localparam logic [7:0] OFF_COUNT_HI = 8'h1c;
	localparam logic [7:0] OFF_CMPA_LO  = 8'h20;
	localparam logic [7:0] OFF_CMPA_HI  = 8'h24;
	localparam logic [7:0] OFF_CMPB_LO  = 8'h28;
	localparam logic [7:0] OFF_CMPB_HI  = 8'h2c;
	localparam logic [7:0] OFF_CAP_LO   = 8'h30;
	localparam logic [7:0] OFF_CAP_HI   = 8'h34;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CA_COMA_POS    = 6;
	localparam int CA_COMB_POS    = 4;
	localparam int CA_WGML_POS    = 0;
	localparam int CB_ICNC_POS    = 7;
	localparam int CB_ICES_POS    = 6;
	localparam int CB_WGMH_POS    = 3;
	localparam int CB_CS_POS      = 0;
	localparam int CC_FOCA_POS    = 7;
	localparam int CC_FOCB_POS    = 6;
	localparam int FLG_TOV        = 0;
	localparam int FLG_OCFA       = 1;
	localparam int FLG_OCFB       = 2;
	localparam int FLG_ICF        = 3;
	localparam int NUM_FLAGS      = 4;
	localparam int PWR_OFF_POS    = 0;
	localparam int PWR_CMPSRC_POS = 1;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0]  RST_CTRL  = 8'h00;
	localparam logic [1:0]  RST_POWER = 2'h1;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [7:0]  RST_BYTE  = 8'h00;

	// ----------------------------------------
	// modes, clock selects, output actions
	// ----------------------------------------
	localparam logic [3:0]  MODE_CTC_A   = 4'h4;
	localparam logic [3:0]  MODE_CTC_ICR = 4'hc;
	localparam logic [3:0]  MODE_PWM_ICR = 4'he;
	localparam logic [3:0]  MODE_PWM_A   = 4'hf;
	localparam logic [2:0]  CS_STOP      = 3'h0;
	localparam logic [2:0]  CS_DIRECT    = 3'h1;
	localparam logic [2:0]  CS_TAP_BASE  = 3'h2;
	localparam logic [2:0]  CS_EXT_FALL  = 3'h6;
	localparam logic [2:0]  CS_EXT_RISE  = 3'h7;
	localparam logic [1:0]  COM_TOGGLE   = 2'h1;
	localparam logic [1:0]  COM_CLEAR    = 2'h2;
	localparam logic [1:0]  COM_SET      = 2'h3;
	localparam logic [15:0] COUNT_MAX    = 16'hffff;
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [2:0]  HSIZE_WORD   = 3'h2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int FILTER_SAMPLES = 4;

endpackage

/* design/sbt_capture_filter.sv */
`timescale 1ns/10ps

module sbt_capture_filter (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic level_in,
	input  wire logic filter_on,
	input  wire logic rising_sel,
	output logic      edge_pulse
);

	typedef struct packed {
		logic [sbt_pkg::FILTER_SAMPLES-1:0] samples;
		logic                               level;
		logic                               pulse;
	} sbt_filter_state_t;

	sbt_filter_state_t st;
	sbt_filter_state_t nx;

	// ----------------------------------------
	// noise canceler and edge detector
	// ----------------------------------------
	always_comb begin
		nx = st;
		nx.samples = {st.samples[sbt_pkg::FILTER_SAMPLES-2:0], level_in};
		if (!filter_on) begin
			nx.level = level_in;
		end else if (&nx.samples) begin
			nx.level = 1'b1;
		end else if (~|nx.samples) begin
			nx.level = 1'b0;
		end
		nx.pulse = (nx.level != st.level) && (nx.level == rising_sel);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign edge_pulse = st.pulse;

endmodule

/* design/sbt_timer.sv */
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps

// Functional notes
// - bottom flag when count is zero
// - max flag when count is all ones
// - top flag at sequence top, fixed, A or capture
// - sixteen-bit registers reached only byte-wise
// - control registers A and B plain eight-bit read/write
// - every request flagged and individually maskable
// - tick from clock, prescaler or pin edge, else idle
// - both compares checked always, drive output pins
// - compare match sets its match flag
// - capture edge copies count into capture
// - noise filter ahead of capture edge detector
// - A as PWM top: no output, buffered
// - capture register may fix the top value
// - one shared eight-bit high-byte holding register
// - low-byte write commits holding plus low byte
// - low-byte read copies high byte to holding
// - compare reads bypass the holding register
// - count high location maps to holding register
// - count write beats clear and count
// - clock select zero stops counter, access stays
module sbt_timer (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [3:0]  prescale_taps,
	input  wire logic        external_count_pin,
	input  wire logic        capture_input_pin,
	input  wire logic        comparator_out,
	output logic      [1:0]  compare_output_pins,
	output logic      [3:0]  timer_requests,
	output logic             at_bottom,
	output logic             at_max,
	output logic             at_top
);

	typedef struct packed {
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [1:0]  power;
		logic [3:0]  flags;
		logic [3:0]  mask;
		logic [15:0] count;
		logic [15:0] cmpa_buf;
		logic [15:0] cmpb_buf;
		logic [15:0] cmpa;
		logic [15:0] cmpb;
		logic [15:0] capture;
		logic [7:0]  temp;
		logic        ext_prev;
		logic        pend;
		logic        pend_write;
		logic        pend_word;
		logic [7:0]  pend_addr;
		logic [31:0] rdata;
		logic        ready;
		logic [1:0]  pins;
		logic [3:0]  req;
		logic        bottom;
		logic        maxed;
		logic        topped;
	} sbt_state_t;

	sbt_state_t  st;
	sbt_state_t  nx;
	logic [3:0]  mode;
	logic [2:0]  clk_sel;
	logic [2:0]  tap_sel;
	logic        power_off;
	logic        pwm_mode;
	logic        icr_top;
	logic        tick_raw;
	logic        tick;
	logic [15:0] top_value;
	logic        wrap;
	logic        match_a;
	logic        match_b;
	logic        cap_pulse;
	logic        cap_event;
	logic        wr_en;
	logic        rd_en;
	logic        cnt_write;
	logic        force_a;
	logic        force_b;
	logic [3:0]  flag_set;
	logic [3:0]  flag_clear;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a, input logic [15:0] c);
		logic [15:0] t;
		t = sbt_pkg::COUNT_MAX;
		if (m == sbt_pkg::MODE_CTC_A || m == sbt_pkg::MODE_PWM_A) begin
			t = a;
		end else if (m == sbt_pkg::MODE_CTC_ICR || m == sbt_pkg::MODE_PWM_ICR) begin
			t = c;
		end
		return t;
	endfunction

	function automatic logic wave(input logic [1:0] com, input logic cur, input logic hit,
		input logic restart, input logic pwm_on);
		logic r;
		r = cur;
		if (pwm_on) begin
			if (com == sbt_pkg::COM_CLEAR) begin
				r = hit ? 1'b0 : (restart ? 1'b1 : cur);
			end else if (com == sbt_pkg::COM_SET) begin
				r = hit ? 1'b1 : (restart ? 1'b0 : cur);
			end
		end else if (hit) begin
			case (com)
				sbt_pkg::COM_TOGGLE: begin
					r = ~cur;
				end
				sbt_pkg::COM_CLEAR: begin
					r = 1'b0;
				end
				sbt_pkg::COM_SET: begin
					r = 1'b1;
				end
				default: begin
					r = cur;
				end
			endcase
		end
		return r;
	endfunction

	// ----------------------------------------
	// mode decode and clock select
	// ----------------------------------------
	assign mode      = {st.ctrl_b[sbt_pkg::CB_WGMH_POS +: 2], st.ctrl_a[sbt_pkg::CA_WGML_POS +: 2]};
	assign clk_sel   = st.ctrl_b[sbt_pkg::CB_CS_POS +: 3];
	assign tap_sel   = clk_sel - sbt_pkg::CS_TAP_BASE;
	assign power_off = st.power[sbt_pkg::PWR_OFF_POS];
	assign pwm_mode  = (mode == sbt_pkg::MODE_PWM_A) || (mode == sbt_pkg::MODE_PWM_ICR);
	assign icr_top   = (mode == sbt_pkg::MODE_CTC_ICR) || (mode == sbt_pkg::MODE_PWM_ICR);

	always_comb begin
		case (clk_sel)
			sbt_pkg::CS_STOP: begin
				tick_raw = 1'b0;
			end
			sbt_pkg::CS_DIRECT: begin
				tick_raw = 1'b1;
			end
			sbt_pkg::CS_EXT_FALL: begin
				tick_raw = st.ext_prev & ~external_count_pin;
			end
			sbt_pkg::CS_EXT_RISE: begin
				tick_raw = ~st.ext_prev & external_count_pin;
			end
			default: begin
				tick_raw = prescale_taps[tap_sel[1:0]];
			end
		endcase
	end

	assign tick      = tick_raw & ~power_off;
	assign top_value = top_of(mode, st.cmpa, st.capture);
	assign wrap      = (st.count == top_value);
	assign match_a   = tick && (st.count == st.cmpa);
	assign match_b   = tick && (st.count == st.cmpb);

	// ----------------------------------------
	// capture source and filter
	// ----------------------------------------
	sbt_capture_filter u_filter (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.level_in   (st.power[sbt_pkg::PWR_CMPSRC_POS] ? comparator_out : capture_input_pin),
		.filter_on  (st.ctrl_b[sbt_pkg::CB_ICNC_POS]),
		.rising_sel (st.ctrl_b[sbt_pkg::CB_ICES_POS]),
		.edge_pulse (cap_pulse)
	);

	assign cap_event = cap_pulse & ~power_off & ~icr_top;

	// ----------------------------------------
	// bus strobes
	// ----------------------------------------
	assign wr_en      = st.pend & st.pend_write & st.pend_word;
	assign rd_en      = st.pend & ~st.pend_write;
	assign cnt_write  = wr_en && (st.pend_addr == sbt_pkg::OFF_COUNT_LO);
	assign force_a    = wr_en && (st.pend_addr == sbt_pkg::OFF_CTRL_C) && hwdata[sbt_pkg::CC_FOCA_POS] && !pwm_mode;
	assign force_b    = wr_en && (st.pend_addr == sbt_pkg::OFF_CTRL_C) && hwdata[sbt_pkg::CC_FOCB_POS] && !pwm_mode;
	assign flag_clear = (wr_en && (st.pend_addr == sbt_pkg::OFF_FLAGS)) ? hwdata[3:0] : 4'h0;

	always_comb begin
		flag_set = 4'h0;
		flag_set[sbt_pkg::FLG_TOV]  = pwm_mode ? (tick && wrap) : (tick && st.count == sbt_pkg::COUNT_MAX);
		flag_set[sbt_pkg::FLG_OCFA] = match_a;
		flag_set[sbt_pkg::FLG_OCFB] = match_b;
		flag_set[sbt_pkg::FLG_ICF]  = icr_top ? (tick && wrap) : cap_event;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nx = st;
		nx.ext_prev = external_count_pin;
		if (tick) begin
			nx.count = wrap ? sbt_pkg::COUNT_BOTTOM : st.count + 16'h0001;
		end
		if (!pwm_mode || (tick && wrap)) begin
			nx.cmpa = st.cmpa_buf;
			nx.cmpb = st.cmpb_buf;
		end
		if (cap_event) begin
			nx.capture = st.count;
		end
		for (int i = 0; i < sbt_pkg::NUM_FLAGS; i++) begin
			nx.flags[i] = flag_set[i] | (st.flags[i] & ~flag_clear[i]);
		end
		nx.pins[0] = wave((mode == sbt_pkg::MODE_PWM_A) ? 2'h0 : st.ctrl_a[sbt_pkg::CA_COMA_POS +: 2],
			st.pins[0], match_a | force_a, tick && wrap, pwm_mode);
		nx.pins[1] = wave(st.ctrl_a[sbt_pkg::CA_COMB_POS +: 2], st.pins[1], match_b | force_b,
			tick && wrap, pwm_mode);
		if (st.pend) begin
			nx.pend  = 1'b0;
			nx.ready = 1'b1;
			nx.rdata = 32'h00000000;
		end
		if (wr_en) begin
			case (st.pend_addr)
				sbt_pkg::OFF_CTRL_A: begin
					nx.ctrl_a = hwdata[7:0];
				end
				sbt_pkg::OFF_CTRL_B: begin
					nx.ctrl_b = hwdata[7:0];
				end
				sbt_pkg::OFF_MASK: begin
					nx.mask = hwdata[3:0];
				end
				sbt_pkg::OFF_POWER: begin
					nx.power = hwdata[1:0];
				end
				sbt_pkg::OFF_COUNT_LO: begin
					nx.count = {st.temp, hwdata[7:0]};
				end
				sbt_pkg::OFF_CMPA_LO: begin
					nx.cmpa_buf = {st.temp, hwdata[7:0]};
				end
				sbt_pkg::OFF_CMPB_LO: begin
					nx.cmpb_buf = {st.temp, hwdata[7:0]};
				end
				sbt_pkg::OFF_CAP_LO: begin
					if (icr_top) begin
						nx.capture = {st.temp, hwdata[7:0]};
					end
				end
				sbt_pkg::OFF_COUNT_HI, sbt_pkg::OFF_CMPA_HI, sbt_pkg::OFF_CMPB_HI, sbt_pkg::OFF_CAP_HI: begin
					nx.temp = hwdata[7:0];
				end
				default: begin
					nx.temp = st.temp;
				end
			endcase
		end
		if (rd_en) begin
			case (st.pend_addr)
				sbt_pkg::OFF_CTRL_A: begin
					nx.rdata = {24'h000000, st.ctrl_a};
				end
				sbt_pkg::OFF_CTRL_B: begin
					nx.rdata = {24'h000000, st.ctrl_b};
				end
				sbt_pkg::OFF_FLAGS: begin
					nx.rdata = {28'h0000000, st.flags};
				end
				sbt_pkg::OFF_MASK: begin
					nx.rdata = {28'h0000000, st.mask};
				end
				sbt_pkg::OFF_POWER: begin
					nx.rdata = {30'h00000000, st.power};
				end
				sbt_pkg::OFF_COUNT_LO: begin
					nx.rdata = {24'h000000, st.count[7:0]};
					nx.temp  = st.count[15:8];
				end
				sbt_pkg::OFF_CMPA_LO: begin
					nx.rdata = {24'h000000, st.cmpa_buf[7:0]};
				end
				sbt_pkg::OFF_CMPA_HI: begin
					nx.rdata = {24'h000000, st.cmpa_buf[15:8]};
				end
				sbt_pkg::OFF_CMPB_LO: begin
					nx.rdata = {24'h000000, st.cmpb_buf[7:0]};
				end
				sbt_pkg::OFF_CMPB_HI: begin
					nx.rdata = {24'h000000, st.cmpb_buf[15:8]};
				end
				sbt_pkg::OFF_CAP_LO: begin
					nx.rdata = {24'h000000, st.capture[7:0]};
					nx.temp  = st.capture[15:8];
				end
				sbt_pkg::OFF_COUNT_HI, sbt_pkg::OFF_CAP_HI: begin
					nx.rdata = {24'h000000, st.temp};
				end
				default: begin
					nx.rdata = 32'h00000000;
				end
			endcase
		end
		if (hsel && htrans[1] && hready) begin
			nx.pend       = 1'b1;
			nx.ready      = 1'b0;
			nx.pend_write = hwrite;
			nx.pend_word  = (hsize == sbt_pkg::HSIZE_WORD);
			nx.pend_addr  = haddr[7:0];
		end
		nx.req    = nx.flags & nx.mask;
		nx.bottom = (nx.count == sbt_pkg::COUNT_BOTTOM);
		nx.maxed  = (nx.count == sbt_pkg::COUNT_MAX);
		nx.topped = (nx.count == top_of({nx.ctrl_b[sbt_pkg::CB_WGMH_POS +: 2], nx.ctrl_a[sbt_pkg::CA_WGML_POS +: 2]},
			nx.cmpa, nx.capture));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st          <= '0;
			st.ctrl_a   <= sbt_pkg::RST_CTRL;
			st.ctrl_b   <= sbt_pkg::RST_CTRL;
			st.power    <= sbt_pkg::RST_POWER;
			st.count    <= sbt_pkg::RST_WORD;
			st.temp     <= sbt_pkg::RST_BYTE;
			st.ready    <= 1'b1;
			st.bottom   <= 1'b1;
			st.topped   <= 1'b0;
		end else begin
			st <= nx;
		end
	end

	assign hrdata              = st.rdata;
	assign hreadyout           = st.ready;
	assign hresp               = 1'b0;
	assign compare_output_pins = st.pins;
	assign timer_requests      = st.req;
	assign at_bottom           = st.bottom;
	assign at_max              = st.maxed;
	assign at_top              = st.topped;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_BOTTOM: assert property (@(posedge hclk) disable iff (!hresetn)
		at_bottom == (st.count == sbt_pkg::COUNT_BOTTOM)) else $error("bottom flag wrong");

	AST_MAX: assert property (@(posedge hclk) disable iff (!hresetn)
		at_max == (st.count == sbt_pkg::COUNT_MAX)) else $error("max flag wrong");

	AST_TOP_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
		(tick && wrap && !cnt_write) |=> (st.count == sbt_pkg::COUNT_BOTTOM)) else $error("no wrap at top");

	AST_LOW_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		cnt_write |=> (st.count == {$past(st.temp), $past(hwdata[7:0])})) else $error("count write lost");

	AST_LOW_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_en && st.pend_addr == sbt_pkg::OFF_COUNT_LO) |=> (st.temp == $past(st.count[15:8])))
		else $error("holding not loaded");

	AST_CMP_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_en && st.pend_addr == sbt_pkg::OFF_CMPA_HI) |=> ($stable(st.temp) && hrdata[7:0] == $past(st.cmpa_buf[15:8])))
		else $error("compare read wrong");

	AST_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_sel == sbt_pkg::CS_STOP && !cnt_write) |=> $stable(st.count)) else $error("counter moved while stopped");

	AST_POWER_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
		(power_off && !cnt_write) |=> $stable(st.count)) else $error("counter moved while powered off");

	AST_MATCH_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
		match_b |=> st.flags[sbt_pkg::FLG_OCFB] ##1
		(st.flags[sbt_pkg::FLG_OCFB] || $past(flag_clear[sbt_pkg::FLG_OCFB]))) else $error("match flag not set");

	AST_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
		cap_event |=> (st.capture == $past(st.count) && st.flags[sbt_pkg::FLG_ICF])) else $error("capture missed");

	AST_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
		timer_requests == (st.flags & st.mask)) else $error("request mask wrong");

	AST_HIGH_TEMP: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && st.pend_addr == sbt_pkg::OFF_COUNT_HI) |=> (st.temp == $past(hwdata[7:0])))
		else $error("high byte not held");

	AST_PWM_A: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == sbt_pkg::MODE_PWM_A) |=> (compare_output_pins[0] == $past(st.pins[0])))
		else $error("A drove PWM while top");

endmodule

/* test/sbt_pin_model.sv */
`timescale 1ns/10ps

module sbt_pin_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	output logic      [3:0] prescale_taps,
	output logic            external_count_pin
);
	logic [3:0] div_reg;

	// ----------------------------------------
	// prescaler strobes, tap k every 2^(k+1) cycles
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg       <= 4'h0;
			prescale_taps <= 4'h0;
		end else begin
			div_reg       <= div_reg + 4'h1;
			prescale_taps <= {&div_reg[3:0], &div_reg[2:0], &div_reg[1:0], div_reg[0]};
		end
	end

	// ----------------------------------------
	// external count pin, pulses on request
	// ----------------------------------------
	initial begin
		external_count_pin = 1'b0;
	end

	task automatic pulse_ext(input int n);
		repeat (n) begin
			@(posedge hclk);
			external_count_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			external_count_pin <= 1'b0;
			repeat (4) @(posedge hclk);
		end
	endtask
endmodule

/* test/sixteen_bit_timer_byte_access_tb.sv */
`timescale 1ns/10ps

module sixteen_bit_timer_byte_access_tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	wire  [3:0]  prescale_taps;
	wire         external_count_pin;
	logic        capture_input_pin;
	logic        comparator_out;
	logic [1:0]  compare_output_pins;
	logic [3:0]  timer_requests;
	logic        at_bottom;
	logic        at_max;
	logic        at_top;
	wire         hready;
	wire  [8:0]  stat;
	int          errors;
	int          checks_done;
	int          cycles;
	logic [31:0] rv;
	logic [31:0] junk;
	logic [15:0] wv;
	logic [15:0] wv2;
	logic        pa;

	assign hready = hreadyout;
	assign stat   = {timer_requests, compare_output_pins, at_top, at_max, at_bottom};

	sbt_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .prescale_taps(prescale_taps),
		.external_count_pin(external_count_pin), .capture_input_pin(capture_input_pin),
		.comparator_out(comparator_out), .compare_output_pins(compare_output_pins),
		.timer_requests(timer_requests), .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));

	sbt_pin_model pm (.hclk(hclk), .hresetn(hresetn), .prescale_taps(prescale_taps),
		.external_count_pin(external_count_pin));

	// ----------------------------------------
	// clock, timeout, verdict
	// ----------------------------------------
	always #5 hclk = ~hclk;

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors = errors + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_le(input logic [31:0] lo, input logic [31:0] hi);
		checks_done++;
		if ((lo <= hi) !== 1'b1) begin
			errors++;
			$display("[ERR] %0t value %h above limit %h", $time, lo, hi);
		end
	endtask

	task automatic chk_st(input logic [8:0] m, input logic [8:0] exp);
		@(negedge hclk);
		chk({23'h0, stat & m}, {23'h0, exp});
	endtask

	// ----------------------------------------
	// bus master, one transfer at a time
	// ----------------------------------------
	task automatic wait_rdy();
		int n;
		n = 0;
		@(negedge hclk);
		while (hready !== 1'b1 && n < 50) begin
			@(negedge hclk);
			n++;
		end
		if (n == 50) begin
			errors++;
			$display("[ERR] %0t no ready", $time);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz,
		output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= sz;
		wait_rdy();
		@(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		@(posedge hclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, sbt_pkg::HSIZE_WORD, junk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		ahb(1'b0, a, 32'h0, sbt_pkg::HSIZE_WORD, q);
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a + 8'h04, {24'h0, v[15:8]});
		wr(a, {24'h0, v[7:0]});
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		logic [31:0] q;
		rd(a, q);
		v[7:0] = q[7:0];
		rd(a + 8'h04, q);
		v[15:8] = q[7:0];
	endtask

	task automatic run(input logic [7:0] cb, input int n);
		wr(sbt_pkg::OFF_CTRL_B, {24'h0, cb});
		repeat (n) @(posedge hclk);
		wr(sbt_pkg::OFF_CTRL_B, {24'h0, cb & 8'hf8});
	endtask

	task automatic cap_pin(input int n);
		@(posedge hclk);
		capture_input_pin <= 1'b1;
		repeat (n) @(posedge hclk);
		capture_input_pin <= 1'b0;
		repeat (10) @(posedge hclk);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		capture_input_pin = 1'b0;
		comparator_out = 1'b0;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(sbt_pkg::OFF_POWER, rv);
		chk(rv, {30'h0, sbt_pkg::RST_POWER});
		chk({31'h0, hresp}, 32'h0);
		chk_st(9'h007, 9'h001);
		wr(sbt_pkg::OFF_CTRL_A, 32'hf3);
		rd(sbt_pkg::OFF_CTRL_A, rv);
		chk(rv, 32'hf3);
		wr(sbt_pkg::OFF_CTRL_B, 32'hd8);
		rd(sbt_pkg::OFF_CTRL_B, rv);
		chk(rv, 32'hd8);
		rd(sbt_pkg::OFF_CTRL_C, rv);
		chk(rv, 32'h0);
		rd(8'h40, rv);
		chk(rv, 32'h0);
		ahb(1'b1, sbt_pkg::OFF_MASK, 32'hf, 3'h0, junk);
		rd(sbt_pkg::OFF_MASK, rv);
		chk(rv, 32'h0);
		wr(sbt_pkg::OFF_CTRL_A, 32'h0);
		wr(sbt_pkg::OFF_CTRL_B, 32'h0);
		run(8'h01, 10);
		rd(sbt_pkg::OFF_COUNT_LO, rv);
		chk(rv, 32'h0);
		wr(sbt_pkg::OFF_POWER, 32'h0);
		// 16-bit access through the holding byte
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h1234);
		rd16(sbt_pkg::OFF_COUNT_LO, wv);
		chk({16'h0, wv}, 32'h1234);
		wr(sbt_pkg::OFF_CMPA_HI, 32'hab);
		wr(sbt_pkg::OFF_CMPA_LO, 32'h01);
		wr(sbt_pkg::OFF_CMPB_LO, 32'h02);
		rd(sbt_pkg::OFF_COUNT_LO, rv);
		rd(sbt_pkg::OFF_CMPA_HI, rv);
		chk(rv, 32'hab);
		rd(sbt_pkg::OFF_CMPB_HI, rv);
		chk(rv, 32'hab);
		rd(sbt_pkg::OFF_COUNT_HI, rv);
		chk(rv, 32'h12);
		// max, top, overflow and masking
		wr16(sbt_pkg::OFF_COUNT_LO, 16'hffff);
		chk_st(9'h007, 9'h006);
		wr(sbt_pkg::OFF_FLAGS, 32'hf);
		wr(sbt_pkg::OFF_MASK, 32'h1);
		run(8'h01, 20);
		rd(sbt_pkg::OFF_FLAGS, rv);
		chk(rv & 32'h1, 32'h1);
		chk_st(9'h020, 9'h020);
		wr(sbt_pkg::OFF_FLAGS, 32'hf);
		chk_st(9'h020, 9'h000);
		rd16(sbt_pkg::OFF_COUNT_LO, wv);
		repeat (20) @(posedge hclk);
		rd16(sbt_pkg::OFF_COUNT_LO, wv2);
		chk({16'h0, wv2}, {16'h0, wv});
		// compare match, flags, output pins
		wr(sbt_pkg::OFF_MASK, 32'h6);
		wr16(sbt_pkg::OFF_CMPA_LO, 16'h0020);
		wr16(sbt_pkg::OFF_CMPB_LO, 16'h0030);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h0000);
		wr(sbt_pkg::OFF_FLAGS, 32'hf);
		wr(sbt_pkg::OFF_CTRL_A, 32'hf0);
		chk_st(9'h0d8, 9'h000);
		run(8'h01, 100);
		chk_st(9'h0d8, 9'h0d8);
		wr(sbt_pkg::OFF_CTRL_A, 32'h50);
		wr(sbt_pkg::OFF_CTRL_C, 32'hc0);
		chk_st(9'h018, 9'h000);
		// clear on compare A
		wr(sbt_pkg::OFF_CTRL_A, 32'h0);
		wr16(sbt_pkg::OFF_CMPA_LO, 16'h0010);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h0000);
		run(8'h09, 100);
		rd16(sbt_pkg::OFF_COUNT_LO, wv);
		chk_le({16'h0, wv}, 32'h10);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h0010);
		chk_st(9'h004, 9'h004);
		// prescaler tap and both pin edges
		wr(sbt_pkg::OFF_CTRL_B, 32'h0);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h0000);
		run(8'h02, 40);
		rd16(sbt_pkg::OFF_COUNT_LO, wv);
		chk_le(32'd15, {16'h0, wv});
		chk_le({16'h0, wv}, 32'd30);
		for (int i = 0; i < 2; i++) begin
			wr16(sbt_pkg::OFF_COUNT_LO, 16'h0000);
			wr(sbt_pkg::OFF_CTRL_B, {29'h0, (i == 0) ? sbt_pkg::CS_EXT_RISE : sbt_pkg::CS_EXT_FALL});
			pm.pulse_ext(5);
			repeat (10) @(posedge hclk);
			wr(sbt_pkg::OFF_CTRL_B, 32'h0);
			rd16(sbt_pkg::OFF_COUNT_LO, wv);
			chk({16'h0, wv}, 32'd5);
		end
		// capture from pin, filter, comparator
		wr(sbt_pkg::OFF_FLAGS, 32'hf);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h4321);
		wr(sbt_pkg::OFF_CTRL_B, 32'h40);
		cap_pin(10);
		rd(sbt_pkg::OFF_FLAGS, rv);
		chk(rv & 32'h8, 32'h8);
		rd16(sbt_pkg::OFF_CAP_LO, wv);
		chk({16'h0, wv}, 32'h4321);
		wr(sbt_pkg::OFF_FLAGS, 32'hf);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h1111);
		wr(sbt_pkg::OFF_CTRL_B, 32'hc0);
		cap_pin(2);
		rd(sbt_pkg::OFF_FLAGS, rv);
		chk(rv & 32'h8, 32'h0);
		cap_pin(12);
		rd16(sbt_pkg::OFF_CAP_LO, wv);
		chk({16'h0, wv}, 32'h1111);
		wr(sbt_pkg::OFF_POWER, 32'h2);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h2222);
		wr(sbt_pkg::OFF_CTRL_B, 32'h40);
		@(posedge hclk);
		comparator_out <= 1'b1;
		repeat (10) @(posedge hclk);
		rd16(sbt_pkg::OFF_CAP_LO, wv);
		chk({16'h0, wv}, 32'h2222);
		// capture as top value
		wr16(sbt_pkg::OFF_CAP_LO, 16'h0008);
		rd16(sbt_pkg::OFF_CAP_LO, wv);
		chk({16'h0, wv}, 32'h2222);
		wr(sbt_pkg::OFF_CTRL_B, 32'h18);
		wr16(sbt_pkg::OFF_CAP_LO, 16'h0008);
		rd16(sbt_pkg::OFF_CAP_LO, wv);
		chk({16'h0, wv}, 32'h0008);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h0008);
		chk_st(9'h004, 9'h004);
		// compare A as pwm top holds output A
		wr(sbt_pkg::OFF_CTRL_A, 32'h83);
		wr16(sbt_pkg::OFF_CMPA_LO, 16'h0040);
		wr16(sbt_pkg::OFF_COUNT_LO, 16'h0000);
		@(negedge hclk);
		pa = compare_output_pins[0];
		wr(sbt_pkg::OFF_CTRL_B, 32'h19);
		for (int i = 0; i < 8; i++) begin
			repeat (25) @(posedge hclk);
			@(negedge hclk);
			chk({31'h0, compare_output_pins[0]}, {31'h0, pa});
		end
		wr(sbt_pkg::OFF_CTRL_B, 32'h18);
		rd16(sbt_pkg::OFF_COUNT_LO, wv);
		chk_le({16'h0, wv}, 32'h40);
		finish_test();
	end
endmodule
